/* design/gas_host_pkg.sv */
// constants, types and notes for the gas sensor i2c host sequencer
// assumes a 100 mhz system clock and an open-drain i2c bus with pull-ups
// Notes on behaviour
// - command words carry embedded 3-bit crc
// - every data word followed by crc byte
// - host may skip crc byte when reading
// - command is start, write header, two bytes
// - host waits, retrying read header until acked; host gives up after retry_max retries and reports nacked
// - host acks bytes to keep data coming
// - after last crc host sends nack, stop
// - early nack and stop ends read
// - power mode command precedes init command
// - measure every 2s or every 30s; host leaves pacing to the requester
// - init again after every power-up
// - restore baseline: init first, then write
package gas_host_pkg;
  localparam logic [6:0]  dev_addr      = 7'h58;
  localparam logic [15:0] cmd_init      = 16'h20ae;
  localparam logic [15:0] cmd_measure   = 16'h2008;
  localparam logic [15:0] cmd_power     = 16'h209f;
  localparam logic [15:0] cmd_base_rd   = 16'h2015;
  localparam logic [15:0] cmd_base_wr   = 16'h201e;
  localparam logic [15:0] mode_ultra    = 16'h0000;
  localparam logic [15:0] mode_low      = 16'h0001;
  localparam logic [7:0]  crc_poly      = 8'h31;
  localparam logic [7:0]  crc_init      = 8'hff;
  localparam int          sys_clk_mhz   = 100;
  localparam int          power_up_us   = 600;
  localparam int          power_up_cyc  = power_up_us * sys_clk_mhz;
  localparam int          exec_ms       = 10;
  localparam int          measure_ms    = 50;
  localparam int          exec_cyc      = exec_ms * 1000 * sys_clk_mhz;
  localparam int          measure_cyc   = measure_ms * 1000 * sys_clk_mhz;
  localparam int          quarter_ns    = 1300;
  localparam int          quarter_cyc   = (quarter_ns * sys_clk_mhz
                                           + 999) / 1000;
  localparam int          retry_max     = 255;

  typedef enum logic [2:0] {
    op_init    = 3'h0,
    op_measure = 3'h1,
    op_power   = 3'h2,
    op_base_rd = 3'h3,
    op_base_wr = 3'h4
  } op_e;

  typedef struct packed {
    op_e         op;
    logic [15:0] param;
  } req_s;

  typedef struct packed {
    logic [15:0] word;
    logic        crc_ok;
    logic        nacked;
  } rsp_s;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } pin_drv_s;
endpackage

/* design/i2c_byte_engine.sv */
// i2c master bit engine: start, stop, byte write and byte read
// assumes open-drain pins resolved outside; oe high pulls the line low
`timescale 1ns/1ns
`default_nettype none
module i2c_byte_engine #(
  parameter int quarter = 13
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // command side
  input  wire logic                  go_i,
  input  wire logic [1:0]            kind_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  ack_send_i,
  output logic                       done_o,
  output logic [7:0]                 rdata_o,
  output logic                       ack_seen_o,
  // pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output gas_host_pkg::pin_drv_s     drv_o
);
  import gas_host_pkg::*;
  // kind: 0 start, 1 stop, 2 write, 3 read
  typedef enum logic [1:0] {
    e_idle = 2'h0,
    e_run  = 2'h1,
    e_done = 2'h2
  } eng_e;
  eng_e        st;
  logic [15:0] tick;
  logic [5:0]  ph;
  logic [1:0]  kind;
  logic [8:0]  sh;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  wire         tick_end = (tick == 16'(quarter - 1));
  wire [3:0]   bit_no   = ph[5:2];
  wire [1:0]   q        = ph[1:0];
  wire [5:0]   last_ph  = (kind[1]) ? 6'h23 : 6'h03;
  // scl stretching is honoured: no advance while we released scl and
  // it still reads low
  wire         stretch  = ~drv_o.scl_oe & ~scl_sync[1] & (q == 2'h2);
  wire         sda_s    = sda_sync[1];

  always_ff @(posedge sys_clk_i) begin
    scl_sync <= {scl_sync[0], scl_i};
    sda_sync <= {sda_sync[0], sda_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= e_idle;
      tick <= 16'h0;
      ph <= 6'h0;
      kind <= 2'h0;
      sh <= 9'h1ff;
      drv_o <= '0;
      rdata_o <= 8'h0;
      ack_seen_o <= 1'b0;
    end else begin
      case (st)
        e_idle: begin
          if (go_i) begin
            st <= e_run;
            kind <= kind_i;
            ph <= 6'h0;
            tick <= 16'h0;
            sh <= {wdata_i, ~ack_send_i};
          end
        end
        e_run: begin
          if (!stretch)
            tick <= tick_end ? 16'h0 : tick + 16'h1;
          if (tick_end && !stretch) begin
            case (kind)
              2'h0: begin
                case (q)
                  2'h0: drv_o <= '0;
                  2'h1: drv_o.sda_oe <= 1'b1;
                  2'h2: drv_o.sda_oe <= 1'b1;
                  default: drv_o.scl_oe <= 1'b1;
                endcase
              end
              2'h1: begin
                case (q)
                  2'h0: drv_o <= '{scl_oe: 1'b1, sda_oe: 1'b1};
                  2'h1: drv_o.scl_oe <= 1'b0;
                  2'h2: drv_o.sda_oe <= 1'b0;
                  default: drv_o <= '0;
                endcase
              end
              default: begin
                case (q)
                  // data bit 8 is the ack slot
                  2'h0: begin
                    drv_o.scl_oe <= 1'b1;
                    drv_o.sda_oe <= (kind == 2'h2 && bit_no != 4'h8)
                                    ? ~sh[8]
                                    : (kind == 2'h3 && bit_no == 4'h8)
                                      ? ~sh[0] : 1'b0;
                  end
                  2'h1: drv_o.scl_oe <= 1'b0;
                  2'h2: begin
                    if (bit_no == 4'h8)
                      ack_seen_o <= ~sda_s;
                    else if (kind == 2'h3)
                      rdata_o <= {rdata_o[6:0], sda_s};
                  end
                  default: begin
                    drv_o.scl_oe <= 1'b1;
                    if (kind == 2'h2)
                      sh <= {sh[7:0], 1'b1};
                  end
                endcase
              end
            endcase
            if (ph == last_ph)
              st <= e_done;
            else
              ph <= ph + 6'h1;
          end
        end
        e_done: st <= e_idle;
        default: st <= e_idle;
      endcase
    end
  end

  assign done_o = (st == e_done);
endmodule
`default_nettype wire

/* design/gas_sensor_host.sv */
// host sequencer driving the gas sensor over i2c
// assumes the user raises req_valid_i with a request struct and holds it
// until req_ready_o; one transaction at a time
`timescale 1ns/1ns
`default_nettype none
module gas_sensor_host #(
  parameter int pu_cycles   = gas_host_pkg::power_up_cyc,
  parameter int exec_cycles = gas_host_pkg::exec_cyc,
  parameter int meas_cycles = gas_host_pkg::measure_cyc,
  parameter int quarter     = gas_host_pkg::quarter_cyc,
  parameter int retries     = gas_host_pkg::retry_max
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_n_i,
  // request side
  input  wire logic                  req_valid_i,
  input  wire gas_host_pkg::req_s    req_i,
  output logic                       req_ready_o,
  // response side
  output logic                       rsp_valid_o,
  output gas_host_pkg::rsp_s         rsp_o,
  // status
  output logic                       ready_o,
  output logic                       inited_o,
  output logic                       order_err_o,
  // i2c pins, oe high pulls low
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       scl_o,
  output logic                       scl_oe_o,
  output logic                       sda_o,
  output logic                       sda_oe_o
);
  import gas_host_pkg::*;
  // byte engine jobs and transfer lengths, header byte included
  localparam logic [1:0] job_start = 2'h0;
  localparam logic [1:0] job_stop  = 2'h1;
  localparam logic [1:0] job_write = 2'h2;
  localparam logic [1:0] job_read  = 2'h3;
  localparam logic [2:0] len_cmd   = 3'h3;
  localparam logic [2:0] len_param = 3'h6;
  localparam logic [1:0] crc_slot  = 2'h2;

  typedef enum logic [3:0] {
    s_power   = 4'h0,
    s_idle    = 4'h1,
    s_start   = 4'h2,
    s_byte    = 4'h3,
    s_stop    = 4'h4,
    s_wait    = 4'h5,
    s_rstart  = 4'h6,
    s_rhdr    = 4'h7,
    s_rbyte   = 4'h8,
    s_rstop   = 4'h9,
    s_done    = 4'ha
  } host_e;

  host_e       st;
  req_s        req;
  logic [31:0] cnt;
  logic [2:0]  bidx;
  logic [1:0]  ridx;
  logic [7:0]  tries;
  logic [7:0]  crc;
  logic [15:0] word;
  logic        nacked;
  logic        crc_ok;
  logic        go;
  logic [1:0]  kind;
  logic [7:0]  wdata;
  logic        eng_done;
  logic [7:0]  eng_rdata;
  logic        eng_ack;
  pin_drv_s    drv;

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ((r << 1) ^ crc_poly) : (r << 1);
    return r;
  endfunction

  // what goes out and what comes back, per operation
  wire         has_param = (req.op == op_power) || (req.op == op_base_wr);
  wire         has_read  = (req.op == op_measure) || (req.op == op_base_rd);
  wire [15:0]  cmd_word  = (req.op == op_init)    ? cmd_init    :
                           (req.op == op_measure) ? cmd_measure :
                           (req.op == op_power)   ? cmd_power   :
                           (req.op == op_base_rd) ? cmd_base_rd :
                                                    cmd_base_wr;
  wire [7:0]   param_crc = crc8(crc8(crc_init, req.param[15:8]),
                                req.param[7:0]);
  wire [2:0]   wr_bytes  = has_param ? len_param : len_cmd;
  // command words already carry their own 3-bit check field
  wire [7:0]   wr_byte   = (bidx == 3'h0) ? {dev_addr, 1'b0} :
                           (bidx == 3'h1) ? cmd_word[15:8]   :
                           (bidx == 3'h2) ? cmd_word[7:0]    :
                           (bidx == 3'h3) ? req.param[15:8]  :
                           (bidx == 3'h4) ? req.param[7:0]   :
                                            param_crc;
  wire [31:0]  wait_cyc  = (req.op == op_measure) ? 32'(meas_cycles)
                                                  : 32'(exec_cycles);
  wire         cnt_zero  = (cnt == 32'h0);
  // decoded transfer points
  wire         last_wr   = (bidx == wr_bytes - 3'h1);
  wire         last_rd   = (ridx == crc_slot);
  // retries spent: the read is reported as refused
  wire         retry_out = (tries == 8'(retries));
  wire         rsp_now   = (st == s_done);
  // init must come after any power mode change and before measurements
  wire         bad_order = (req_i.op == op_power && inited_o)
                        || (req_i.op == op_measure && !inited_o)
                        || (req_i.op == op_base_wr && !inited_o);

  i2c_byte_engine #(
    .quarter    (quarter)
  ) u_engine (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .go_i       (go),
    .kind_i     (kind),
    .wdata_i    (wdata),
    .ack_send_i (!last_rd),
    .done_o     (eng_done),
    .rdata_o    (eng_rdata),
    .ack_seen_o (eng_ack),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .drv_o      (drv)
  );

  always_comb begin
    go = 1'b0;
    kind = job_start;
    wdata = 8'hff;
    case (st)
      s_start, s_rstart: begin
        go = 1'b1;
        kind = job_start;
      end
      s_byte: begin
        go = 1'b1;
        kind = job_write;
        wdata = wr_byte;
      end
      s_rhdr: begin
        go = 1'b1;
        kind = job_write;
        wdata = {dev_addr, 1'b1};
      end
      s_rbyte: begin
        go = 1'b1;
        kind = job_read;
      end
      s_stop, s_rstop: begin
        go = 1'b1;
        kind = job_stop;
      end
      default: go = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= s_power;
      req <= '0;
      cnt <= 32'h0;
      bidx <= 3'h0;
      ridx <= 2'h0;
      tries <= 8'h0;
      crc <= crc_init;
      word <= 16'h0;
      nacked <= 1'b0;
      crc_ok <= 1'b0;
      inited_o <= 1'b0;
      order_err_o <= 1'b0;
    end else begin
      case (st)
        s_power: begin
          // hold off until the sensor has surely reached idle
          cnt <= cnt + 32'h1;
          if (cnt >= 32'(pu_cycles) - 32'h1) begin
            st <= s_idle;
            cnt <= 32'h0;
          end
        end
        s_idle: begin
          order_err_o <= 1'b0;
          if (req_valid_i) begin
            req <= req_i;
            order_err_o <= bad_order;
            bidx <= 3'h0;
            nacked <= 1'b0;
            word <= 16'h0;
            crc_ok <= 1'b0;
            st <= s_start;
          end
        end
        s_start: if (eng_done) st <= s_byte;
        s_byte: begin
          if (eng_done) begin
            if (!eng_ack) begin
              nacked <= 1'b1;
              st <= s_stop;
            end else if (last_wr) begin
              st <= s_stop;
            end else begin
              bidx <= bidx + 3'h1;
            end
          end
        end
        s_stop: begin
          if (eng_done) begin
            cnt <= wait_cyc;
            tries <= 8'h0;
            st <= (nacked || !has_read) ? s_done : s_wait;
            if (!nacked && req.op == op_init)
              inited_o <= 1'b1;
          end
        end
        s_wait: begin
          if (cnt_zero) begin
            st <= s_rstart;
            ridx <= 2'h0;
            crc <= crc_init;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        s_rstart: if (eng_done) st <= s_rhdr;
        s_rhdr: begin
          if (eng_done) begin
            if (eng_ack) begin
              st <= s_rbyte;
            end else if (retry_out) begin
              nacked <= 1'b1;
              st <= s_rstop;
            end else begin
              // busy sensor: back off one execution slot then poll again
              tries <= tries + 8'h1;
              cnt <= 32'(exec_cycles);
              st <= s_rstop;
            end
          end
        end
        s_rbyte: begin
          if (eng_done) begin
            crc <= crc8(crc, eng_rdata);
            if (ridx == 2'h0)
              word[15:8] <= eng_rdata;
            else if (ridx == 2'h1)
              word[7:0] <= eng_rdata;
            else
              crc_ok <= (crc == eng_rdata);
            // ack msb and lsb, nack after the crc byte
            if (last_rd)
              st <= s_rstop;
            else
              ridx <= ridx + 2'h1;
          end
        end
        s_rstop: begin
          if (eng_done) begin
            if (last_rd || nacked)
              st <= s_done;
            else
              st <= s_wait;
          end
        end
        s_done: st <= s_idle;
        default: st <= s_idle;
      endcase
    end
  end

  // response stands until the next transaction ends
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
    end else begin
      rsp_valid_o <= rsp_now;
      if (rsp_now) begin
        rsp_o.word <= has_read ? word : 16'h0;
        rsp_o.crc_ok <= has_read ? crc_ok : 1'b1;
        rsp_o.nacked <= nacked;
      end
    end
  end

  // pacing of measure requests is left to the requester
  assign req_ready_o = (st == s_idle);
  assign ready_o     = (st != s_power);
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_o    = drv.scl_oe;
  assign sda_oe_o    = drv.sda_oe;
endmodule
`default_nettype wire

/* dv/gas_host_checker.sv */
// checker: handshake, ordering and bus-release assertions on host ports
// assumes the bind below attaches it to every host instance
`timescale 1ns/1ns
`default_nettype none
module gas_host_checker (
  // clock and reset
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  // request, response, status
  input wire logic               req_valid_i,
  input wire gas_host_pkg::req_s req_i,
  input wire logic               req_ready_o,
  input wire logic               rsp_valid_o,
  input wire gas_host_pkg::rsp_s rsp_o,
  input wire logic               ready_o,
  input wire logic               inited_o,
  input wire logic               order_err_o,
  // pins
  input wire logic               scl_i,
  input wire logic               sda_i,
  input wire logic               scl_o,
  input wire logic               scl_oe_o,
  input wire logic               sda_o,
  input wire logic               sda_oe_o
);
  import gas_host_pkg::*;
  logic busy;
  op_e  op;
  wire  take = req_valid_i && req_ready_o;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      op   <= op_init;
    end else if (take) begin
      busy <= 1'b1;
      op   <= req_i.op;
    end else if (rsp_valid_o) begin
      busy <= 1'b0;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_release_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !scl_oe_o && !sda_oe_o && !rsp_valid_o)
    else $error("bus not released in reset");
  ready_gate_a: assert property (!ready_o |-> !req_ready_o)
    else $error("request taken before power-up wait");
  ready_hold_a: assert property (ready_o |=> ready_o)
    else $error("ready dropped");
  take_busy_a: assert property (take |=> !req_ready_o until rsp_valid_o)
    else $error("second request taken in flight");
  rsp_pulse_a: assert property (rsp_valid_o |-> busy ##1 !rsp_valid_o)
    else $error("response without request or too long");
  idle_bus_a: assert property (req_ready_o |-> !scl_oe_o && !sda_oe_o)
    else $error("bus held while idle");
  drive_low_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  init_flag_a: assert property (rsp_valid_o && op == op_init
    && !rsp_o.nacked |=> inited_o) else $error("init not recorded");
  measure_order_a: assert property (take && req_i.op == op_measure
    && !inited_o |=> order_err_o) else $error("measure before init unflagged");
  power_order_a: assert property (take && req_i.op == op_power
    && inited_o |=> order_err_o) else $error("late power mode unflagged");
  read_order_a: assert property (take && req_i.op == op_base_rd
    |=> !order_err_o) else $error("baseline read flagged");
  measure_c: cover property (take && req_i.op == op_measure);
  nacked_c: cover property (rsp_valid_o && rsp_o.nacked);
  order_c: cover property ($rose(order_err_o));
endmodule
bind gas_sensor_host gas_host_checker chk_u (.sys_clk_i, .rst_n_i,
  .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .ready_o,
  .inited_o, .order_err_o, .scl_i, .sda_i, .scl_o, .scl_oe_o, .sda_o,
  .sda_oe_o);
`default_nettype wire

/* dv/gas_dev_model.sv */
// sensor model: i2c target with command, measure and baseline behaviour
// assumes the bench resolves the open-drain wires and feeds levels back
`timescale 1ns/1ns
`default_nettype none
module gas_dev_model #(
  parameter logic [15:0] base_ulp = 16'h1357,
  parameter logic [15:0] base_lp  = 16'h2468,
  parameter int          zero_n   = 1
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // bus levels and drive
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_oe_o,
  // slow measurement, refuse address
  input  wire logic slow_i,
  input  wire logic refuse_i
);
  import gas_host_pkg::*;
  logic        scl_q, sda_q, rd, mack, ok;
  logic [7:0]  sh, ob;
  logic [15:0] w;
  logic [15:0] base [2];
  logic [7:0]  wq [$];
  logic [7:0]  rq [$];
  int          bits, idx, busy, mcnt, mode;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  task automatic put(input logic [15:0] v);
    rq.delete();
    rq.push_back(v[15:8]);
    rq.push_back(v[7:0]);
    rq.push_back(crc8(v));
  endtask
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode = 1;
      base[0] = base_ulp;
      base[1] = base_lp;
      busy = 10;
      mcnt = 0;
      idx = -1;
      rd = 1'b0;
      rq.delete();
      sda_oe_o <= 1'b0;
    end else begin
      if (busy > 0) busy--;
      if (scl_i && scl_q && sda_q && !sda_i) begin
        bits = 0;
        idx = 0;
        rd = 1'b0;
        wq.delete();
        sda_oe_o <= 1'b0;
      end else if (scl_i && scl_q && !sda_q && sda_i) begin
        if (rd) rq.delete();
        ok = wq.size() == 5;
        if (ok) begin
          w = {wq[2], wq[3]};
          ok = crc8(w) == wq[4];
        end
        if (!rd && wq.size() >= 2) begin
          case ({wq[0], wq[1]})
            cmd_init: mcnt = 0;
            cmd_measure: begin
              mcnt++;
              put(mcnt <= zero_n ? 16'h0 : 16'h0100 + 16'(mcnt));
            end
            cmd_power: if (ok) mode = (w == mode_ultra) ? 0 : 1;
            cmd_base_rd: put(base[mode]);
            cmd_base_wr: if (ok) base[mode] = w;
            default: ;
          endcase
        end
        idx = -1;
        sda_oe_o <= 1'b0;
      end else if (idx >= 0 && scl_i && !scl_q) begin
        if (bits < 8) sh = {sh[6:0], sda_i};
        else mack = !sda_i;
        bits++;
      end else if (idx >= 0 && !scl_i && scl_q) begin
        if (bits == 8 && !rd) begin
          ok = idx > 0 || (sh[7:1] == dev_addr && busy == 0 && !refuse_i);
          if (idx == 0) rd = ok && sh[0];
          else wq.push_back(sh);
          if (idx == 2 && {wq[0], wq[1]} == cmd_measure)
            busy = slow_i ? 400 : 20;
          sda_oe_o <= ok;
          if (!ok) idx = -1;
        end else if (bits == 9) begin
          bits = 0;
          idx++;
          if (rd && (idx == 1 || mack)) begin
            ob = rq.size() > 0 ? rq.pop_front() : 8'hff;
            sda_oe_o <= !ob[7];
          end else begin
            sda_oe_o <= 1'b0;
            if (rd) idx = -1;
          end
        end else if (rd) sda_oe_o <= bits < 8 ? !ob[7-bits] : 1'b0;
      end
    end
    scl_q = scl_i;
    sda_q = sda_i;
  end
endmodule
`default_nettype wire

/* dv/gas_sensor_host_tb_top.sv */
// self-checking bench for the gas sensor host sequencer
// assumes the sensor model on the far side of a pulled-up open-drain bus
`timescale 1ns/1ns
`default_nettype none
module gas_sensor_host_tb_top;
  import gas_host_pkg::*;
  localparam logic [15:0] base_ulp = 16'h1357;
  localparam logic [15:0] base_lp  = 16'h2468;
  logic sys_clk_i, rst_n_i, req_valid_i, slow, refuse, dev_oe, err_seen;
  logic req_ready_o, rsp_valid_o, ready_o, inited_o, order_err_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o;
  req_s req_i;
  rsp_s rsp_o;
  logic [15:0] base [2];
  logic [15:0] p;
  int err_count = 0, samples_checked = 0, cycles = 0, mode, mcnt;
  // pull-ups: a line is low while any party enables its driver
  wire scl_w = !scl_oe_o;
  wire sda_w = !(sda_oe_o || dev_oe);
  gas_sensor_host #(.pu_cycles(20), .exec_cycles(50), .meas_cycles(50),
    .quarter(4), .retries(8)) dut_u (.sys_clk_i, .rst_n_i, .req_valid_i,
    .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .ready_o, .inited_o,
    .order_err_o, .scl_i(scl_w), .sda_i(sda_w), .scl_o, .scl_oe_o, .sda_o,
    .sda_oe_o);
  gas_dev_model #(.base_ulp(base_ulp), .base_lp(base_lp)) dev_u (
    .sys_clk_i, .rst_n_i, .scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(dev_oe),
    .slow_i(slow), .refuse_i(refuse));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // a hung handshake ends the run here
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk1(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0b seen %0b", n, e, g);
    end
  endtask
  task automatic chk16(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until taken, then wait for the response pulse
  task automatic do_req(input op_e op, input logic [15:0] prm);
    req_valid_i <= 1'b1;
    req_i <= '{op: op, param: prm};
    @(posedge sys_clk_i);
    while (req_ready_o !== 1'b1) @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
    err_seen = 1'b0;
    do begin
      @(posedge sys_clk_i);
      err_seen |= order_err_o === 1'b1;
    end while (rsp_valid_o !== 1'b1);
  endtask
  task automatic expect_rd(input string n, input logic [15:0] e);
    chk16(n, e, rsp_o.word);
    chk1("crc_ok", 1'b1, rsp_o.crc_ok);
    chk1("nacked", 1'b0, rsp_o.nacked);
  endtask
  initial begin
    void'($urandom(32'h7a66));
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    slow = 1'b0;
    refuse = 1'b0;
    mode = 1;
    mcnt = 0;
    base[0] = base_ulp;
    base[1] = base_lp;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk1("ready_early", 1'b0, ready_o);
    do_req(op_measure, 16'h0000);
    mcnt++;
    chk1("order_err", 1'b1, err_seen);
    expect_rd("tvoc", 16'h0000);
    do_req(op_power, mode_ultra);
    mode = 0;
    chk1("order_err", 1'b0, err_seen);
    do_req(op_init, 16'h0000);
    mcnt = 0;
    @(posedge sys_clk_i);
    chk1("inited", 1'b1, inited_o);
    do_req(op_base_rd, 16'h0000);
    expect_rd("baseline", base[mode]);
    p = 16'($urandom);
    do_req(op_base_wr, p);
    base[mode] = p;
    chk1("nacked", 1'b0, rsp_o.nacked);
    do_req(op_base_rd, 16'h0000);
    expect_rd("baseline", base[mode]);
    for (int i = 0; i < 2; i++) begin
      slow <= (i == 0);
      do_req(op_measure, 16'h0000);
      mcnt++;
      expect_rd("tvoc", mcnt <= 1 ? 16'h0 : 16'h0100 + 16'(mcnt));
    end
    do_req(op_power, mode_low);
    mode = 1;
    chk1("order_err", 1'b1, err_seen);
    do_req(op_base_rd, 16'h0000);
    expect_rd("baseline", base[mode]);
    refuse <= 1'b1;
    do_req(op_base_wr, ~base[1]);
    chk1("nacked", 1'b1, rsp_o.nacked);
    refuse <= 1'b0;
    do_req(op_base_rd, 16'h0000);
    expect_rd("baseline", base[mode]);
    test_done();
  end
endmodule
`default_nettype wire
